// ==== card_reader_power_detect.sv ====
// card reader supply, pin control and card detect with an APB slave
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module card_reader_power_detect
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_detect_input,
    input wire logic card_reset_sense,
    input wire logic card_data_in,
    input wire logic card_aux_a_in,
    input wire logic card_aux_b_in,
    input wire card_reader_pkg::uart_drive_s uart_drive,
    output card_reader_pkg::card_pins_s card_pins,
    output card_reader_pkg::power_ctrl_s power_ctrl,
    output logic card_insert_req,
    output logic card_remove_req
);

    // ************************************************************
    // state
    // ************************************************************
    card_reader_pkg::state_s state_reg;
    card_reader_pkg::state_s state_next;

    logic setup_phase;
    logic access_phase;
    logic write_lane0;
    logic addr_mapped;
    logic present_now;
    logic detect_edge;
    logic flag_clear;
    logic [31:0] read_value;
    logic [1:0] supply_sel;

    // ************************************************************
    // bus phase decode
    // ************************************************************
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign write_lane0 = access_phase & pwrite & pstrb[0];

    always_comb
    begin
        addr_mapped = 1'b0;
        if (paddr == card_reader_pkg::boost_ctrl_off)
        begin
            addr_mapped = 1'b1;
        end
        else if (paddr == card_reader_pkg::card_ctrl_off)
        begin
            addr_mapped = 1'b1;
        end
        else if (paddr == card_reader_pkg::pin_option_off)
        begin
            addr_mapped = 1'b1;
        end
        else if (paddr == card_reader_pkg::card_status_off)
        begin
            addr_mapped = 1'b1;
        end
    end

    // ************************************************************
    // card presence
    // ************************************************************
    // polarity 0: switch closes to ground, card present when pin is low
    assign present_now = state_reg.detect_sync[1] ^
        ~state_reg.card_ctrl[card_reader_pkg::detect_polarity_bit];

    // edge taken on the pin itself, so a polarity write raises no request
    assign detect_edge = state_reg.detect_sync[1] ^
        state_reg.detect_prev;

    // writing 0 to the flag clears it; writing 1 leaves it alone
    assign flag_clear = write_lane0 & addr_mapped &
        (paddr == card_reader_pkg::card_status_off) &
        ~pwdata[card_reader_pkg::presence_flag_bit];

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (paddr == card_reader_pkg::boost_ctrl_off)
        begin
            read_value[7:0] = state_reg.boost_ctrl;
        end
        else if (paddr == card_reader_pkg::card_ctrl_off)
        begin
            read_value[7:0] = state_reg.card_ctrl;
            // reset bit reads back the pin, not the written value
            read_value[card_reader_pkg::reset_line_bit] =
                state_reg.reset_sync[1];
        end
        else if (paddr == card_reader_pkg::pin_option_off)
        begin
            read_value[7:0] = state_reg.pin_option;
        end
        else if (paddr == card_reader_pkg::card_status_off)
        begin
            read_value[card_reader_pkg::presence_flag_bit] =
                state_reg.presence_flag;
            read_value[card_reader_pkg::present_now_bit] = present_now;
            read_value[card_reader_pkg::reset_sense_bit] =
                state_reg.reset_sync[1];
            read_value[card_reader_pkg::data_sense_bit] =
                state_reg.data_sync[1];
            read_value[card_reader_pkg::aux_a_sense_bit] =
                state_reg.aux_a_sync[1];
            read_value[card_reader_pkg::aux_b_sense_bit] =
                state_reg.aux_b_sync[1];
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;

        // two-stage synchronisers for every pin input
        state_next.detect_sync = {state_reg.detect_sync[0],
            card_detect_input};
        state_next.reset_sync = {state_reg.reset_sync[0],
            card_reset_sense};
        state_next.data_sync = {state_reg.data_sync[0], card_data_in};
        state_next.aux_a_sync = {state_reg.aux_a_sync[0], card_aux_a_in};
        state_next.aux_b_sync = {state_reg.aux_b_sync[0], card_aux_b_in};

        // no filter: the edge is seen two cycles after the pin moves
        state_next.detect_prev = state_reg.detect_sync[1];
        state_next.insert_pulse = detect_edge & present_now &
            state_reg.card_ctrl[card_reader_pkg::detect_req_enable_bit];
        state_next.remove_pulse = detect_edge & ~present_now &
            state_reg.card_ctrl[card_reader_pkg::detect_req_enable_bit];

        // set wins over a clear in the same cycle
        state_next.presence_flag = present_now |
            (state_reg.presence_flag & ~flag_clear);

        // read data is captured in setup so prdata comes from a flop
        if (setup_phase)
        begin
            state_next.rdata = read_value;
            state_next.slverr = ~addr_mapped;
        end

        if (write_lane0 & addr_mapped)
        begin
            if (paddr == card_reader_pkg::boost_ctrl_off)
            begin
                state_next.boost_ctrl = pwdata[7:0] &
                    card_reader_pkg::boost_ctrl_mask;
            end
            else if (paddr == card_reader_pkg::card_ctrl_off)
            begin
                state_next.card_ctrl = pwdata[7:0];
            end
            else if (paddr == card_reader_pkg::pin_option_off)
            begin
                state_next.pin_option = pwdata[7:0] &
                    card_reader_pkg::pin_option_mask;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg.boost_ctrl <= card_reader_pkg::boost_ctrl_rst;
            state_reg.card_ctrl <= card_reader_pkg::card_ctrl_rst;
            state_reg.pin_option <= card_reader_pkg::pin_option_rst;
            state_reg.presence_flag <= 1'b0;
            state_reg.detect_sync <= card_reader_pkg::detect_sync_rst;
            state_reg.detect_prev <= card_reader_pkg::detect_prev_rst;
            state_reg.reset_sync <= 2'h0;
            state_reg.data_sync <= 2'h0;
            state_reg.aux_a_sync <= 2'h0;
            state_reg.aux_b_sync <= 2'h0;
            state_reg.insert_pulse <= 1'b0;
            state_reg.remove_pulse <= 1'b0;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.slverr <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // bus outputs
    // ************************************************************
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = access_phase & state_reg.slverr;

    // ************************************************************
    // power control
    // ************************************************************
    assign supply_sel = {
        state_reg.card_ctrl[card_reader_pkg::supply_sel_hi_bit],
        state_reg.card_ctrl[card_reader_pkg::supply_sel_lo_bit]};

    always_comb
    begin
        power_ctrl.boost_level_select =
            state_reg.boost_ctrl[card_reader_pkg::boost_level_bit];
        // a 0V card supply shuts the converter whatever enable says
        power_ctrl.boost_run =
            state_reg.boost_ctrl[card_reader_pkg::boost_enable_bit] &
            (supply_sel != card_reader_pkg::supply_off_code);
        power_ctrl.card_supply_select = supply_sel;
        power_ctrl.detect_pullup_enable =
            state_reg.pin_option[card_reader_pkg::pullup_enable_bit];
    end

    // ************************************************************
    // card pins
    // ************************************************************
    always_comb
    begin
        card_pins.reset_line =
            state_reg.card_ctrl[card_reader_pkg::reset_line_bit];
        if (state_reg.card_ctrl[card_reader_pkg::auto_transfer_bit])
        begin
            card_pins.clock_line = uart_drive.clock_line;
            card_pins.data_out = uart_drive.data_out;
            card_pins.data_oe = uart_drive.data_oe;
        end
        else
        begin
            // manual data is open-drain: drive only a low, release a high
            card_pins.clock_line =
                state_reg.card_ctrl[card_reader_pkg::manual_clock_bit];
            card_pins.data_out = 1'b0;
            card_pins.data_oe =
                ~state_reg.card_ctrl[card_reader_pkg::manual_data_bit];
        end
        card_pins.aux_a_out =
            state_reg.pin_option[card_reader_pkg::aux_a_out_bit];
        card_pins.aux_a_oe =
            state_reg.pin_option[card_reader_pkg::aux_a_oe_bit];
        card_pins.aux_b_out =
            state_reg.pin_option[card_reader_pkg::aux_b_out_bit];
        card_pins.aux_b_oe =
            state_reg.pin_option[card_reader_pkg::aux_b_oe_bit];
    end

    // ************************************************************
    // detect requests
    // ************************************************************
    // one-cycle pulses; activation and deactivation are left to software
    assign card_insert_req = state_reg.insert_pulse;
    assign card_remove_req = state_reg.remove_pulse;

endmodule // card_reader_power_detect

`default_nettype wire

// ==== card_reader_pkg.sv ====
// constants and carrier types for the card reader supply and detect block
//
// Behaviour
// - boost level select 0 targets 3.8V, 1 targets 5.5V.
// - boost enable runs the converter; cleared it only passes supply through.
// - card supply select at 0V forces the converter off despite enable.
// - two-bit supply select picks 1.8V, 3.0V or 5.0V card supply.
// - reset control bit drives the card reset line; read returns pin.
// - clock and data lines follow the card UART or two manual bits.
// - two auxiliary contacts are general I/O, two control bits each (output value and output enable).
// - card insertion raises an insertion request when detect enable is set.
// - card removal raises a removal request under the same enable.
// - polarity bit adapts presence to normally-open or normally-closed switch.
// - presence flag is set while a card is present; software clears it.
// - no debounce; every detect level change shows on the present-now status bit two cycles later.
// - pull-up enable bit connects the detect pull-high resistor.
// - transfer mode 1 gives UART pin operation, 0 gives manual operation.

package card_reader_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] boost_ctrl_off = 12'h000;
    localparam logic [11:0] card_ctrl_off = 12'h004;
    localparam logic [11:0] pin_option_off = 12'h008;
    localparam logic [11:0] card_status_off = 12'h00C;

    localparam logic [7:0] boost_ctrl_rst = 8'h00;
    localparam logic [7:0] card_ctrl_rst = 8'h00;
    localparam logic [7:0] pin_option_rst = 8'h00;
    // detect pin idles high: no false presence straight after reset
    localparam logic [1:0] detect_sync_rst = 2'h3;
    localparam logic detect_prev_rst = 1'h1;

    // ************************************************************
    // field positions
    // ************************************************************
    // card_supply_boost_control
    localparam int boost_level_bit = 0;
    localparam int boost_enable_bit = 1;
    localparam logic [7:0] boost_ctrl_mask = 8'h03;
    // card_control_reg
    localparam int supply_sel_lo_bit = 0;
    localparam int supply_sel_hi_bit = 1;
    localparam int reset_line_bit = 2;
    localparam int manual_clock_bit = 3;
    localparam int manual_data_bit = 4;
    localparam int auto_transfer_bit = 5;
    localparam int detect_polarity_bit = 6;
    localparam int detect_req_enable_bit = 7;
    // card_pin_option_reg
    localparam int pullup_enable_bit = 0;
    localparam int aux_a_out_bit = 1;
    localparam int aux_b_out_bit = 2;
    localparam int aux_a_oe_bit = 3;
    localparam int aux_b_oe_bit = 4;
    localparam logic [7:0] pin_option_mask = 8'h1F;
    // card_status_reg
    localparam int presence_flag_bit = 0;
    localparam int present_now_bit = 1;
    localparam int reset_sense_bit = 2;
    localparam int data_sense_bit = 3;
    localparam int aux_a_sense_bit = 4;
    localparam int aux_b_sense_bit = 5;

    // supply select code that means 0V
    localparam logic [1:0] supply_off_code = 2'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic clock_line;
        logic data_out;
        logic data_oe;
    } uart_drive_s;

    typedef struct packed {
        logic reset_line;
        logic clock_line;
        logic data_out;
        logic data_oe;
        logic aux_a_out;
        logic aux_a_oe;
        logic aux_b_out;
        logic aux_b_oe;
    } card_pins_s;

    typedef struct packed {
        logic boost_run;
        logic boost_level_select;
        logic [1:0] card_supply_select;
        logic detect_pullup_enable;
    } power_ctrl_s;

    typedef struct packed {
        logic [7:0] boost_ctrl;
        logic [7:0] card_ctrl;
        logic [7:0] pin_option;
        logic presence_flag;
        logic [1:0] detect_sync;
        logic detect_prev;
        logic [1:0] reset_sync;
        logic [1:0] data_sync;
        logic [1:0] aux_a_sync;
        logic [1:0] aux_b_sync;
        logic insert_pulse;
        logic remove_pulse;
        logic [31:0] rdata;
        logic slverr;
    } state_s;

endpackage

// ==== card_reader_sva.sv ====
// port assertions for the card reader supply and detect block
`timescale 1ns/1ps
`default_nettype none
module card_reader_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic card_detect_input,
    input wire card_reader_pkg::uart_drive_s uart_drive,
    input wire card_reader_pkg::card_pins_s card_pins,
    input wire card_reader_pkg::power_ctrl_s power_ctrl,
    input wire logic card_insert_req,
    input wire logic card_remove_req
);
    // ****************
    // write strobes
    // ****************
    logic wr;
    assign wr = psel && penable && pwrite && pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // checks
    // ****************
    boost_off_a: assert property (
        power_ctrl.card_supply_select == 2'h0 |-> !power_ctrl.boost_run)
        else $error("boost runs with card supply off");
    boost_level_a: assert property (
        wr && paddr == 12'h000 |=>
        power_ctrl.boost_level_select == $past(pwdata[0]))
        else $error("boost level does not follow its bit");
    boost_run_a: assert property (
        wr && paddr == 12'h000 |=> power_ctrl.boost_run ==
        ($past(pwdata[1]) && power_ctrl.card_supply_select != 2'h0))
        else $error("boost run does not follow enable");
    supply_sel_a: assert property (
        wr && paddr == 12'h004 |=>
        power_ctrl.card_supply_select == $past(pwdata[1:0]) &&
        card_pins.reset_line == $past(pwdata[2]))
        else $error("supply or reset line wrong after write");
    manual_pin_a: assert property (
        wr && paddr == 12'h004 && !pwdata[5] |=>
        card_pins[6:4] == {$past(pwdata[3]), 1'h0, !$past(pwdata[4])})
        else $error("manual clock or data drive wrong");
    auto_pin_a: assert property (
        wr && paddr == 12'h004 && pwdata[5] |=>
        card_pins[6:4] == uart_drive)
        else $error("auto mode does not pass uart drive");
    aux_pin_a: assert property (
        wr && paddr == 12'h008 |=> card_pins[3:0] == {$past(pwdata[1]),
        $past(pwdata[3]), $past(pwdata[2]), $past(pwdata[4])} &&
        power_ctrl.detect_pullup_enable == $past(pwdata[0]))
        else $error("aux pins or pull-up wrong after write");
    req_pulse_a: assert property (
        !(card_insert_req && card_remove_req) and
        (card_insert_req |=> !card_insert_req) and
        (card_remove_req |=> !card_remove_req))
        else $error("detect request not a single pulse");
    req_cause_a: assert property (
        card_insert_req || card_remove_req |->
        $past(card_detect_input, 3) != $past(card_detect_input, 4))
        else $error("detect request without detect edge");
endmodule // card_reader_sva
bind card_reader_power_detect card_reader_sva i_sva (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .card_detect_input,
    .uart_drive, .card_pins, .power_ctrl, .card_insert_req,
    .card_remove_req);
`default_nettype wire

// ==== card_socket_model.sv ====
// socket switch and card contact model
`timescale 1ns/1ps
`default_nettype none
module card_socket_model
(
    input wire logic pclk,
    input wire logic present,
    input wire logic closed_type,
    input wire card_reader_pkg::card_pins_s card_pins,
    input wire card_reader_pkg::power_ctrl_s power_ctrl,
    output logic card_detect_input,
    output logic card_reset_sense,
    output logic card_data_in,
    output logic card_aux_a_in,
    output logic card_aux_b_in
);
    // ****************
    // contacts
    // ****************
    logic float_reg = 1'h0;
    logic closed;
    // open switch without pull-up floats: show a changing level
    always @(posedge pclk)
        float_reg <= ~float_reg;
    assign closed = present ^ closed_type;
    assign card_detect_input = closed ? 1'h0 :
        (power_ctrl.detect_pullup_enable ? 1'h1 : float_reg);
    assign card_reset_sense = card_pins.reset_line;
    // card side pull-ups on the contacts
    assign card_data_in = card_pins.data_oe ? card_pins.data_out : 1'h1;
    assign card_aux_a_in = card_pins.aux_a_oe ? card_pins.aux_a_out : 1'h1;
    assign card_aux_b_in = card_pins.aux_b_oe ? card_pins.aux_b_out : 1'h1;
endmodule // card_socket_model
`default_nettype wire

// ==== tb.sv ====
// testbench for the card reader supply and detect block
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic [4:0] p;
    } row_s;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, card_insert_req, card_remove_req;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic err, present = 1'h0, closed_type = 1'h0, uart_on = 1'h0;
    logic card_detect_input, card_reset_sense, card_data_in;
    logic card_aux_a_in, card_aux_b_in;
    card_reader_pkg::uart_drive_s uart_drive = 3'h1;
    card_reader_pkg::card_pins_s card_pins;
    card_reader_pkg::power_ctrl_s power_ctrl;
    int num_errors = 0, tests_run = 0, ins_n = 0, rem_n = 0, ucnt = 0;
    int e_ins = 0, e_rem = 0;
    row_s rows [11];
    card_reader_power_detect i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .card_detect_input, .card_reset_sense, .card_data_in,
        .card_aux_a_in, .card_aux_b_in, .uart_drive, .card_pins,
        .power_ctrl, .card_insert_req, .card_remove_req);
    card_socket_model i_card (.pclk, .present, .closed_type, .card_pins,
        .power_ctrl, .card_detect_input, .card_reset_sense, .card_data_in,
        .card_aux_a_in, .card_aux_b_in);
    // ****************
    // clock, link clock, counters
    // ****************
    initial
        forever #2 pclk = ~pclk;
    // 48 ns link clock, still outside frames
    always @(posedge pclk)
    begin
        ucnt <= (ucnt == 5) ? 0 : ucnt + 1;
        if (uart_on && ucnt == 5)
            uart_drive <= {~uart_drive[2], uart_drive[2], 1'h1};
        if (card_insert_req === 1'h1)
            ins_n <= ins_n + 1;
        if (card_remove_req === 1'h1)
            rem_n <= rem_n + 1;
    end
    // ****************
    // tasks
    // ****************
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 64);
        if (pready !== 1'h1)
            num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk_reg(input string s, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk_pin(input string s, input logic [7:0] e,
        input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk_reg("read", {24'h0, e}, rd);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_req(input int i, input int r);
        repeat (8) @(posedge pclk);
        e_ins += i;
        e_rem += r;
        chk_reg("ins", e_ins, ins_n);
        chk_reg("rem", e_rem, rem_n);
    endtask
    // ****************
    // sequence
    // ****************
    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end
    initial
    begin
        rows = '{{12'h000, 8'h03, 8'h03, 5'h08}, {12'h004, 8'h03, 8'h03, 5'h1E},
            {12'h004, 8'h01, 8'h01, 5'h1A}, {12'h004, 8'h02, 8'h02, 5'h1C},
            {12'h000, 8'h02, 8'h02, 5'h14}, {12'h000, 8'h00, 8'h00, 5'h04},
            {12'h000, 8'h01, 8'h01, 5'h0C}, {12'h008, 8'h01, 8'h01, 5'h0D},
            {12'h000, 8'h03, 8'h03, 5'h1D}, {12'h004, 8'h00, 8'h00, 5'h09},
            {12'h020, 8'h55, 8'h00, 5'h09}};
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i])
        begin
            apb(1'h1, rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].r);
            chk_pin("power", {3'h0, rows[i].p},
                {3'h0, power_ctrl});
            chk_reg("slverr", {31'h0, rows[i].a == 12'h020}, {31'h0, err});
        end
        presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        chk_pin("power", 8'h00, {3'h0, power_ctrl});
        chk_pin("pins", 8'h10, card_pins);
        rd_chk(12'h000, 8'h00);
        rd_chk(12'h004, 8'h00);
        rd_chk(12'h008, 8'h00);
        apb(1'h1, 12'h008, 8'h1B);
        apb(1'h1, 12'h004, 8'h0F);
        apb(1'h1, 12'h00C, 8'h00);
        chk_pin("pins", 8'hDD, card_pins);
        rd_chk(12'h004, 8'h0F);
        rd_chk(12'h00C, 8'h14);
        uart_on <= 1'h1;
        apb(1'h1, 12'h004, 8'h23);
        repeat (4)
        begin
            repeat (5) @(posedge pclk);
            @(negedge pclk);
            chk_pin("uart", {5'h0, uart_drive}, {5'h0, card_pins[6:4]});
        end
        uart_on <= 1'h0;
        apb(1'h1, 12'h004, 8'h83);
        present <= 1'h1;
        wait_req(1, 0);
        rd_chk(12'h00C, 8'h13);
        apb(1'h1, 12'h004, 8'h87);
        present <= 1'h0;
        wait_req(0, 1);
        rd_chk(12'h00C, 8'h15);
        apb(1'h1, 12'h00C, 8'h00);
        rd_chk(12'h00C, 8'h14);
        apb(1'h1, 12'h004, 8'h83);
        for (int i = 0; i < 3; i++)
        begin
            present <= ~present;
            repeat (6) @(posedge pclk);
        end
        wait_req(2, 1);
        apb(1'h1, 12'h004, 8'h03);
        present <= 1'h0;
        wait_req(0, 0);
        apb(1'h1, 12'h004, 8'h43);
        closed_type <= 1'h1;
        repeat (6) @(posedge pclk);
        apb(1'h1, 12'h00C, 8'h00);
        apb(1'h1, 12'h004, 8'hC3);
        present <= 1'h1;
        wait_req(1, 0);
        rd_chk(12'h00C, 8'h13);
        apb(1'h1, 12'h004, 8'h83);
        wait_req(0, 0);
        test_done();
    end
endmodule // tb
`default_nettype wire
